/* src/css_defs.vh */
`ifndef CSS_DEFS_VH
`define CSS_DEFS_VH

// ----------------------------------------------------------------
// Register port offsets (byte addresses)
// ----------------------------------------------------------------
`define CSS_REG_PAGE_ADDR     8'h00
`define CSS_REG_WRITE_MASK    8'h04
`define CSS_REG_INT_MASK      8'h08
`define CSS_REG_INT_STATUS    8'h0C
`define CSS_REG_CSB_MASK      8'h10
`define CSS_REG_CONTROL       8'h14
`define CSS_REG_STATE         8'h18

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CSS_RST_PAGE_ADDR     32'h00000000
`define CSS_RST_WRITE_MASK    10'h3FF
`define CSS_RST_INT_MASK      10'h3FF
`define CSS_RST_CSB_MASK      16'h0000
`define CSS_RST_CONTROL       4'h0

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CSS_CTL_FAULT_REPAIR  0
`define CSS_CTL_ARB_ENABLE    1
`define CSS_CTL_ALLOW_ELEM    2
`define CSS_CTL_ALLOW_WFE     3

// ----------------------------------------------------------------
// Interrupt status vector bit positions
// ----------------------------------------------------------------
`define CSS_INT_USER          0
`define CSS_INT_ENGINE_ERR    3
`define CSS_INT_FLUSH         4
`define CSS_INT_L3_PARITY     5
`define CSS_INT_MEDIA_CNT     6
`define CSS_INT_PAGE_FAULT    7
`define CSS_INT_CTX_SWITCH    8
`define CSS_INT_WIDTH         10
// Bits never mirrored to the status page, and bits that hold state
`define CSS_INT_NO_MIRROR     10'h1C0
`define CSS_INT_STICKY        10'h171

// ----------------------------------------------------------------
// Status page layout (offsets and entry counts inside the 4KB page)
// ----------------------------------------------------------------
`define CSS_PAGE_MASK         32'hFFFFF000
`define CSS_PG_INT_STATUS     12'h000
`define CSS_PG_CSB_DW         12'h028
`define CSS_PG_LAST_QW        4'hF
`define CSS_CSB_ENTRIES       4'hC
`define CSS_CSB_LAST          4'hB

`endif

/* src/css_status_report.v */
`timescale 1ns/10ps
`default_nettype none

`include "css_defs.vh"

// Behaviour
// - Status buffer at dword 28h, twelve entries
// - Switch writes status to next ascending entry
// - After entry 11 pointer wraps to 0
// - Pointer value written to quadword 15 low byte
// - Pointer names entry written; upper bits zero
// - Unmasked reasons report entry and interrupt
// - Masked reason: no entry, no interrupt
// - New list preempts at next preemptable command
// - Preempted context saved to its image address
// - Preemption points need arbitration enabled
// - Status page accesses are cacheable, snooped
// - One common interrupt bit layout
// - Status change writes unmasked bits outside 8:6 to page
// - Bit 8 on switch, never mirrored
// - Bit 7 set while translation fault pending
// - Fault repair mode ignores interrupt mask for bit 7
// - Bit 6 media counter, media only, unmirrored
// - Bit 5 cache parity, render only
// - Bit 3 follows engine error
module css_status_report #(
    parameter IS_RENDER = 1,
    parameter IS_MEDIA  = 0,
    parameter REASON_W  = 16
) (
    // Clock and reset
    input  wire                 ref_clk,
    input  wire                 rst,
    // Register port
    input  wire [7:0]           reg_addr,
    input  wire [31:0]          reg_wdata,
    input  wire                 reg_wr,
    input  wire                 reg_rd,
    output reg  [31:0]          reg_rdata,
    // Context switch events from the engine
    input  wire                 ctx_switch,
    input  wire [REASON_W-1:0]  switch_reason,
    input  wire [63:0]          ctx_status,
    output reg                  ctx_switch_ready,
    // Execution list submission and preemption
    input  wire                 execlist_submit_port,
    input  wire                 arbitration_check_cmd,
    input  wire                 elem_boundary,
    input  wire                 sem_wait_fail,
    input  wire                 wfe_fail,
    input  wire [31:0]          context_image_address,
    output reg                  preempt_go,
    output reg                  ctx_save_req,
    output reg  [31:0]          ctx_save_addr,
    input  wire                 ctx_save_ack,
    // Interrupt sources
    input  wire                 user_event,
    input  wire                 flush_event,
    input  wire                 l3_parity_event,
    input  wire                 media_count_event,
    input  wire                 fault_pending,
    input  wire                 engine_error,
    output reg                  engine_irq,
    // Status page memory writes
    output reg                  mem_req,
    output reg  [31:0]          mem_addr,
    output reg  [63:0]          mem_data,
    output reg                  mem_snoop,
    input  wire                 mem_ack
);

    // ----------------------------------------------------------------
    // Local constants
    // ----------------------------------------------------------------
    localparam MS_IDLE = 1'b0;
    localparam MS_BUSY = 1'b1;

    localparam SEL_ENTRY = 2'h0;
    localparam SEL_LAST  = 2'h1;
    localparam SEL_INT   = 2'h2;

    // Offsets are added, not ORed: the buffer base shares bits with the index
    localparam [11:0] CSB_BASE = `CSS_PG_CSB_DW << 2;

    localparam [9:0] EVT_MEDIA_EN  = (IS_MEDIA != 0)  ? 10'h3FF : 10'h000;
    localparam [9:0] EVT_RENDER_EN = (IS_RENDER != 0) ? 10'h3FF : 10'h000;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [31:0]              page_addr_q;
    reg  [9:0]               write_mask_q;
    reg  [9:0]               int_mask_q;
    reg  [9:0]               int_status_q;
    reg  [9:0]               int_status_d;
    reg  [REASON_W-1:0]      csb_mask_q;
    reg  [3:0]               control_q;
    reg  [3:0]               wptr_q;
    reg  [3:0]               wptr_d;
    reg  [63:0]              entry_data_q;
    reg                      pend_entry_q;
    reg                      pend_last_q;
    reg                      pend_int_q;
    reg                      preempt_pend_q;
    reg                      mstate_q;
    reg  [1:0]               sel_q;

    wire                     fault_repair = control_q[`CSS_CTL_FAULT_REPAIR];
    wire                     arb_enable   = control_q[`CSS_CTL_ARB_ENABLE];
    wire                     allow_elem   = control_q[`CSS_CTL_ALLOW_ELEM];
    wire                     allow_wfe    = control_q[`CSS_CTL_ALLOW_WFE];

    wire                     switch_take  = ctx_switch & ctx_switch_ready;
    wire                     switch_rep   = switch_take & (|(switch_reason & ~csb_mask_q));
    wire                     wr_int_st    = reg_wr & (reg_addr == `CSS_REG_INT_STATUS);
    wire                     mem_done     = (mstate_q == MS_BUSY) & mem_ack;

    // Effective mirror mask: some bits can never be mirrored
    wire [9:0]               mirror_bits  = int_status_q & ~(write_mask_q | `CSS_INT_NO_MIRROR);

    // ----------------------------------------------------------------
    // Preemption point detection
    // ----------------------------------------------------------------
    wire                     preempt_point = arb_enable & (arbitration_check_cmd |
                                             (elem_boundary & allow_elem) | sem_wait_fail |
                                             (wfe_fail & allow_wfe));

    // ----------------------------------------------------------------
    // Interrupt status vector next value
    // ----------------------------------------------------------------
    always @* begin
        int_status_d = int_status_q;
        // Write-one clears sticky bits; events below override the clear
        if (wr_int_st) begin
            int_status_d = int_status_q & ~(reg_wdata[9:0] & `CSS_INT_STICKY);
        end
        if (user_event) begin
            int_status_d[`CSS_INT_USER] = 1'b1;
        end
        if (flush_event) begin
            int_status_d[`CSS_INT_FLUSH] = 1'b1;
        end
        if (l3_parity_event & EVT_RENDER_EN[`CSS_INT_L3_PARITY]) begin
            int_status_d[`CSS_INT_L3_PARITY] = 1'b1;
        end
        if (media_count_event & EVT_MEDIA_EN[`CSS_INT_MEDIA_CNT]) begin
            int_status_d[`CSS_INT_MEDIA_CNT] = 1'b1;
        end
        if (switch_rep) begin
            int_status_d[`CSS_INT_CTX_SWITCH] = 1'b1;
        end
        // Level sources track their cause, not software
        int_status_d[`CSS_INT_PAGE_FAULT] = fault_pending;
        int_status_d[`CSS_INT_ENGINE_ERR] = engine_error;
        int_status_d[2] = 1'b0;
        int_status_d[1] = 1'b0;
        int_status_d[9] = 1'b0;
    end

    // ----------------------------------------------------------------
    // Write pointer next value
    // ----------------------------------------------------------------
    always @* begin
        if (wptr_q == `CSS_CSB_LAST) begin
            wptr_d = 4'h0;
        end else begin
            wptr_d = wptr_q + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            page_addr_q  <= `CSS_RST_PAGE_ADDR;
            write_mask_q <= `CSS_RST_WRITE_MASK;
            int_mask_q   <= `CSS_RST_INT_MASK;
            csb_mask_q   <= `CSS_RST_CSB_MASK;
            control_q    <= `CSS_RST_CONTROL;
            reg_rdata    <= 32'h00000000;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `CSS_REG_PAGE_ADDR:  page_addr_q  <= reg_wdata & `CSS_PAGE_MASK;
                    `CSS_REG_WRITE_MASK: write_mask_q <= reg_wdata[9:0];
                    `CSS_REG_INT_MASK:   int_mask_q   <= reg_wdata[9:0];
                    `CSS_REG_CSB_MASK:   csb_mask_q   <= reg_wdata[REASON_W-1:0];
                    `CSS_REG_CONTROL:    control_q    <= reg_wdata[3:0];
                    default: ;
                endcase
            end
            if (reg_rd) begin
                case (reg_addr)
                    `CSS_REG_PAGE_ADDR:  reg_rdata <= page_addr_q;
                    `CSS_REG_WRITE_MASK: reg_rdata <= {22'h000000, write_mask_q};
                    `CSS_REG_INT_MASK:   reg_rdata <= {22'h000000, int_mask_q};
                    `CSS_REG_INT_STATUS: reg_rdata <= {22'h000000, int_status_q};
                    `CSS_REG_CSB_MASK:   reg_rdata <= {{(32-REASON_W){1'b0}}, csb_mask_q};
                    `CSS_REG_CONTROL:    reg_rdata <= {28'h0000000, control_q};
                    `CSS_REG_STATE:      reg_rdata <= {26'h0000000, preempt_pend_q,
                                                      mstate_q, wptr_q};
                    default:             reg_rdata <= 32'h00000000;
                endcase
            end else begin
                reg_rdata <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status and interrupt output
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            int_status_q <= 10'h000;
            engine_irq   <= 1'b0;
        end else begin
            int_status_q <= int_status_d;
            // Fault repair lets a fault through regardless of the mask
            engine_irq   <= (|(int_status_d & ~int_mask_q)) |
                            (fault_repair & int_status_d[`CSS_INT_PAGE_FAULT]);
        end
    end

    // ----------------------------------------------------------------
    // Context switch capture
    // ----------------------------------------------------------------
    // One switch is held at a time; ready drops until both writes land
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wptr_q           <= `CSS_CSB_LAST;
            entry_data_q     <= 64'h0000000000000000;
            pend_entry_q     <= 1'b0;
            pend_last_q      <= 1'b0;
            ctx_switch_ready <= 1'b0;
        end else begin
            if (switch_rep) begin
                wptr_q       <= wptr_d;
                entry_data_q <= ctx_status;
                pend_entry_q <= 1'b1;
                pend_last_q  <= 1'b1;
            end else if (mem_done) begin
                if (sel_q == SEL_ENTRY) begin
                    pend_entry_q <= 1'b0;
                end
                if (sel_q == SEL_LAST) begin
                    pend_last_q <= 1'b0;
                end
            end
            ctx_switch_ready <= ~(switch_rep | pend_entry_q | pend_last_q) |
                                (mem_done & (sel_q == SEL_LAST));
        end
    end

    // ----------------------------------------------------------------
    // Status mirror request
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend_int_q <= 1'b0;
        end else begin
            // A fresh change beats completion of the older write
            if (int_status_d != int_status_q) begin
                pend_int_q <= 1'b1;
            end else if (mem_done & (sel_q == SEL_INT)) begin
                pend_int_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Status page write sequencer
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mstate_q  <= MS_IDLE;
            sel_q     <= SEL_ENTRY;
            mem_req   <= 1'b0;
            mem_addr  <= 32'h00000000;
            mem_data  <= 64'h0000000000000000;
            mem_snoop <= 1'b0;
        end else begin
            case (mstate_q)
                MS_IDLE: begin
                    if (pend_entry_q) begin
                        mstate_q  <= MS_BUSY;
                        sel_q     <= SEL_ENTRY;
                        mem_req   <= 1'b1;
                        mem_addr  <= page_addr_q |
                                     {20'h00000,
                                      CSB_BASE + {5'h00, wptr_q, 3'h0}};
                        mem_data  <= entry_data_q;
                        mem_snoop <= 1'b1;
                    end else if (pend_last_q) begin
                        mstate_q  <= MS_BUSY;
                        sel_q     <= SEL_LAST;
                        mem_req   <= 1'b1;
                        mem_addr  <= page_addr_q |
                                     {20'h00000,
                                      CSB_BASE + {5'h00, `CSS_PG_LAST_QW, 3'h0}};
                        mem_data  <= {60'h000000000000000, wptr_q};
                        mem_snoop <= 1'b1;
                    end else if (pend_int_q) begin
                        mstate_q  <= MS_BUSY;
                        sel_q     <= SEL_INT;
                        mem_req   <= 1'b1;
                        mem_addr  <= page_addr_q | {20'h00000, `CSS_PG_INT_STATUS};
                        mem_data  <= {54'h00000000000000, mirror_bits};
                        mem_snoop <= 1'b1;
                    end else begin
                        mem_req   <= 1'b0;
                    end
                end
                MS_BUSY: begin
                    if (mem_ack) begin
                        mstate_q <= MS_IDLE;
                        mem_req  <= 1'b0;
                    end
                end
                default: begin
                    mstate_q <= MS_IDLE;
                    mem_req  <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Preemption
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            preempt_pend_q <= 1'b0;
            preempt_go     <= 1'b0;
            ctx_save_req   <= 1'b0;
            ctx_save_addr  <= 32'h00000000;
        end else begin
            // New submission wins over the clear from a preemption
            if (execlist_submit_port) begin
                preempt_pend_q <= 1'b1;
            end else if (preempt_pend_q & preempt_point & ~ctx_save_req) begin
                preempt_pend_q <= 1'b0;
            end
            preempt_go <= preempt_pend_q & preempt_point & ~ctx_save_req;
            if (preempt_pend_q & preempt_point & ~ctx_save_req) begin
                ctx_save_req  <= 1'b1;
                ctx_save_addr <= context_image_address;
            end else if (ctx_save_ack) begin
                ctx_save_req  <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

/* test/css_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module css_monitor (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Register port
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Preemption
    input wire logic        arbitration_check_cmd,
    input wire logic        elem_boundary,
    input wire logic        sem_wait_fail,
    input wire logic        wfe_fail,
    input wire logic        preempt_go,
    input wire logic        ctx_save_req,
    input wire logic [31:0] ctx_save_addr,
    input wire logic        ctx_save_ack,
    // Status page writes
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic [63:0] mem_data,
    input wire logic        mem_snoop,
    input wire logic        mem_ack
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [11:0] offs;
    logic [11:0] rel;
    logic        is_entry;
    logic        pt_any;
    logic [3:0]  last_idx_q;
    assign offs     = mem_addr[11:0];
    assign rel      = offs - 12'h0A0;
    assign is_entry = offs >= 12'h0A0 && offs <= 12'h0F8 && offs[2:0] == 3'h0;
    assign pt_any   = arbitration_check_cmd | elem_boundary | sem_wait_fail | wfe_fail;
    // Index of the entry last accepted, for the pointer quadword
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            last_idx_q <= 4'hF;
        else if (mem_req && mem_ack && is_entry)
            last_idx_q <= rel[6:3];
    end
    AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> mem_req
        && $stable(mem_addr) && $stable(mem_data)) else $error("mem write not held");
    AST_MEM_DROP: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("req not dropped");
    AST_SNOOP: assert property (mem_req |-> mem_snoop)
        else $error("not snooped");
    AST_MEM_PLACE: assert property (mem_req |-> offs == 12'h000 || offs == 12'h118
        || is_entry) else $error("bad write place");
    AST_QW15_AFTER: assert property (mem_req && mem_ack && is_entry
        |-> ##[2:10] (mem_req && offs == 12'h118)) else $error("pointer write missing");
    AST_QW15_DATA: assert property (mem_req && offs == 12'h118
        |-> mem_data == {60'h0, last_idx_q}) else $error("pointer value wrong");
    AST_GO_PULSE: assert property (preempt_go |-> ctx_save_req ##1 !preempt_go)
        else $error("bad go pulse");
    AST_GO_POINT: assert property (preempt_go |-> $past(pt_any))
        else $error("go without point");
    AST_SAVE_HOLD: assert property (ctx_save_req && !ctx_save_ack
        |=> ctx_save_req && $stable(ctx_save_addr)) else $error("save request not held");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("stray read data");
endmodule
bind css_status_report css_monitor u_mon (.ref_clk, .rst, .reg_rd, .reg_rdata,
    .arbitration_check_cmd, .elem_boundary, .sem_wait_fail, .wfe_fail, .preempt_go,
    .ctx_save_req, .ctx_save_addr, .ctx_save_ack, .mem_req, .mem_addr, .mem_data,
    .mem_snoop, .mem_ack);
`default_nettype wire

/* test/css_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module css_mem_model (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Answer pacing and page view
    input  wire logic        slow,
    input  wire logic [31:0] page_base,
    output var  logic [63:0] mirror_q,
    // Status page writes
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic [63:0] mem_data,
    output var  logic        mem_ack,
    // Context save
    input  wire logic        ctx_save_req,
    output var  logic        ctx_save_ack
);
    logic [2:0] mcnt_q;
    logic [2:0] scnt_q;
    logic [2:0] dly;
    // Slow answers exercise held requests
    assign dly = slow ? 3'h5 : 3'h0;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_ack      <= 1'b0;
            ctx_save_ack <= 1'b0;
            mcnt_q       <= 3'h0;
            scnt_q       <= 3'h0;
            mirror_q     <= 64'h0;
        end else begin
            mem_ack      <= 1'b0;
            ctx_save_ack <= 1'b0;
            if (mem_req && !mem_ack) begin
                mcnt_q  <= (mcnt_q >= dly) ? 3'h0 : mcnt_q + 3'h1;
                mem_ack <= mcnt_q >= dly;
                if (mcnt_q >= dly && mem_addr == page_base)
                    mirror_q <= mem_data;
            end
            if (ctx_save_req && !ctx_save_ack) begin
                scnt_q       <= (scnt_q >= dly) ? 3'h0 : scnt_q + 3'h1;
                ctx_save_ack <= scnt_q >= dly;
            end
        end
    end
endmodule
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [31:0] PAGE = 32'h00123000;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        ctx_switch = 1'b0;
    logic [15:0] switch_reason = 16'h0;
    logic [63:0] ctx_status = 64'h0;
    logic        submit = 1'b0;
    logic [3:0]  pts = 4'h0;
    logic [31:0] cia = 32'h0;
    logic [3:0]  evs = 4'h0;
    logic        fault = 1'b0;
    logic        err = 1'b0;
    logic        slow = 1'b0;
    logic        rd_pend = 1'b0;
    logic [31:0] reg_rdata, ctx_save_addr, mem_addr;
    logic [63:0] mem_data, mirror_q;
    logic        ctx_switch_ready, preempt_go, ctx_save_req, ctx_save_ack;
    logic        engine_irq, mem_req, mem_snoop, mem_ack;
    logic [95:0] memq [$];
    logic [31:0] rdq [$];
    logic [31:0] goq [$];
    int          errors = 0;
    int          checks_done = 0;
    int          exp_idx = 11;

    always #50 ref_clk = ~ref_clk;

    css_status_report uut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .ctx_switch, .switch_reason, .ctx_status, .ctx_switch_ready,
        .execlist_submit_port(submit), .arbitration_check_cmd(pts[0]),
        .elem_boundary(pts[1]), .sem_wait_fail(pts[2]), .wfe_fail(pts[3]),
        .context_image_address(cia), .preempt_go, .ctx_save_req, .ctx_save_addr,
        .ctx_save_ack, .user_event(evs[0]), .flush_event(evs[1]),
        .l3_parity_event(evs[2]), .media_count_event(evs[3]), .fault_pending(fault),
        .engine_error(err), .engine_irq, .mem_req, .mem_addr, .mem_data, .mem_snoop,
        .mem_ack);
    css_mem_model u_mem (.ref_clk(ref_clk), .rst(rst), .slow(slow), .page_base(PAGE),
        .mirror_q(mirror_q), .mem_req(mem_req), .mem_addr(mem_addr), .mem_data(mem_data),
        .mem_ack(mem_ack), .ctx_save_req(ctx_save_req), .ctx_save_ack(ctx_save_ack));

    task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        rdq.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
    endtask
    task automatic sw(input logic [15:0] rsn, input logic rep);
        logic [63:0] st;
        int          n;
        st = {$urandom, $urandom};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ctx_switch_ready !== 1'b1 && n < 200);
        ctx_switch    <= 1'b1;
        switch_reason <= rsn;
        ctx_status    <= st;
        @(posedge ref_clk);
        ctx_switch <= 1'b0;
        if (rep) begin
            exp_idx = (exp_idx == 11) ? 0 : exp_idx + 1;
            memq.push_back({PAGE + 32'h0A0 + 32'(8 * exp_idx), st});
            memq.push_back({PAGE + 32'h118, 64'(exp_idx)});
        end
    endtask
    task automatic conclude();
        if (errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Result watcher: oldest note against each read, entry or pointer write and go; mirror writes only checked for bits 8:6
    always @(posedge ref_clk) begin
        if (rd_pend)
            chk("reg_rdata", {64'h0, rdq.pop_front()}, {64'h0, reg_rdata});
        rd_pend <= reg_rd;
        if (mem_req === 1'b1 && mem_ack === 1'b1) begin
            if (mem_addr === PAGE)
                chk("mirror bits 8:6", 96'h0, {32'h0, mem_data & 64'h1C0});
            else if (memq.size() == 0)
                chk("unexpected mem write", 96'h0, {mem_addr, mem_data});
            else
                chk("mem write", memq.pop_front(), {mem_addr, mem_data});
        end
        if (preempt_go === 1'b1)
            chk("ctx_save_addr", {64'h0, goq.size() ? goq.pop_front() : ~ctx_save_addr},
                {64'h0, ctx_save_addr});
    end

    initial begin
        #1000000;
        errors++;
        conclude();
    end

    initial begin
        logic [55:0] ra = 56'hFC181410080400;
        logic [31:0] re [7] = '{32'h0, 32'h3FF, 32'h3FF, 32'h0, 32'h0, 32'hB, 32'h0};
        logic [27:0] pv = 28'h8842211;
        logic [27:0] pc = 28'hA226220;
        logic [6:0]  pe = 7'h5A;
        void'($urandom(32'h013D));
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++)
            rd(ra[8*i +: 8], re[i]);
        wr(8'h00, PAGE);
        for (int i = 0; i < 13; i++) begin
            slow <= i[0];
            sw(16'($urandom_range(16'hFFFF, 1)), 1'b1);
        end
        tick(40);
        wr(8'h0C, 32'h3FF);
        wr(8'h10, 32'h00FF);
        sw(16'h0041, 1'b0);
        tick(5);
        rd(8'h0C, 32'h0);
        sw(16'h0100, 1'b1);
        tick(3);
        rd(8'h0C, 32'h100);
        tick(20);
        // Refused points keep the list pending
        for (int i = 0; i < 7; i++) begin
            wr(8'h14, {28'h0, pc[4*i +: 4]});
            @(posedge ref_clk);
            submit <= 1'b1;
            cia    <= $urandom;
            @(posedge ref_clk);
            submit <= 1'b0;
            pts    <= pv[4*i +: 4];
            if (pe[i])
                goq.push_back(cia);
            @(posedge ref_clk);
            pts <= 4'h0;
            tick(12);
        end
        chk("pending saves", 96'h0, 96'(goq.size()));
        wr(8'h04, 32'h0);
        fault <= 1'b1;
        err   <= 1'b1;
        evs   <= 4'hF;
        @(posedge ref_clk);
        evs <= 4'h0;
        tick(3);
        rd(8'h0C, 32'h1B9);
        chk("engine_irq masked", 96'h0, {95'h0, engine_irq});
        wr(8'h14, 32'h1);
        tick(2);
        chk("engine_irq repair", 96'h1, {95'h0, engine_irq});
        tick(30);
        chk("mirror", 96'h39, {32'h0, mirror_q});
        fault <= 1'b0;
        err   <= 1'b0;
        tick(30);
        rd(8'h0C, 32'h131);
        chk("mirror cleared", 96'h31, {32'h0, mirror_q});
        wr(8'h14, 32'h0);
        wr(8'h08, 32'h3FE);
        tick(2);
        chk("engine_irq unmasked", 96'h1, {95'h0, engine_irq});
        wr(8'h0C, 32'h1);
        tick(2);
        chk("engine_irq cleared", 96'h0, {95'h0, engine_irq});
        tick(5);
        conclude();
    end
endmodule
`default_nettype wire
